// *** hdl/crr_exec.sv ***
/*
 * Execution of relative call, software reset, return from interrupt and
 * return with literal. Assumes the fetch unit presents one word per cycle
 * with instr_valid, and that the stack, W, STATUS and bank register live
 * outside and take the strobes driven here in the following cycle.
 * Stack overflow and underflow are left to the stack itself.
 */
`timescale 1ns/10ps
module crr_exec #(
	parameter int PC_W = crr_pkg::PC_W
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [15:0] instr,
	input wire logic instr_valid,
	input wire logic [PC_W-1:0] instr_pc,
	input wire logic [PC_W-1:0] stack_top,
	input wire logic irq_low_level,
	input wire logic [7:0] work_reg_shadow,
	input wire logic [7:0] status_shadow,
	input wire logic [7:0] bank_select_shadow,
	output logic stack_push,
	output logic [PC_W-1:0] stack_push_data,
	output logic stack_pop,
	output logic pc_load,
	output logic [PC_W-1:0] pc_next,
	output logic work_we,
	output logic [7:0] work_data,
	output logic status_we,
	output logic [7:0] status_data,
	output logic bank_we,
	output logic [7:0] bank_data,
	output logic irq_en_high_set,
	output logic irq_en_low_set,
	output logic soft_reset,
	output logic busy
);
	crr_pkg::crr_op_e op;
	logic idle_q;
	logic exec;
	logic restore;
	logic [PC_W-1:0] disp;
	logic take_call;
	logic take_retirq;
	logic take_retlit;
	logic take_reset;
	logic take_none;

	// Call match on the top five bits
	crr_decode u_dec (
		.instr(instr),
		.op(op)
	);

	// ========================================
	// Sequencing
	// Word fetched during the idle slot is stale; drop it
	assign exec = instr_valid && !idle_q;
	assign busy = idle_q;
	assign restore = instr[crr_pkg::FLD_RESTORE];
	// Sign-extend then double
	assign disp = PC_W'({{(PC_W - 12){instr[10]}}, instr[10:0], 1'b0});
	// Word taken this cycle, by kind
	assign take_call = exec && op == crr_pkg::CRR_CALL;
	assign take_retirq = exec && op == crr_pkg::CRR_RETIRQ;
	assign take_retlit = exec && op == crr_pkg::CRR_RETLIT;
	assign take_reset = exec && op == crr_pkg::CRR_RESET;
	assign take_none = exec && op == crr_pkg::CRR_NONE;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			idle_q <= 1'b0;
		end else begin
			idle_q <= exec && (op == crr_pkg::CRR_CALL
				|| op == crr_pkg::CRR_RETIRQ
				|| op == crr_pkg::CRR_RETLIT);
		end
	end

	// ========================================
	// Stack and program counter
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stack_push <= 1'b0;
			stack_push_data <= crr_pkg::PC_RESET;
			stack_pop <= 1'b0;
			pc_load <= 1'b0;
			pc_next <= crr_pkg::PC_RESET;
		end else begin
			stack_push <= 1'b0;
			stack_pop <= 1'b0;
			pc_load <= 1'b0;
			if (exec) begin
				case (op)
				crr_pkg::CRR_CALL: begin
					stack_push <= 1'b1;
					stack_push_data <= instr_pc + crr_pkg::PC_STEP;
					pc_load <= 1'b1;
					pc_next <= instr_pc + crr_pkg::PC_STEP + disp;
				end
				crr_pkg::CRR_RETIRQ, crr_pkg::CRR_RETLIT: begin
					stack_pop <= 1'b1;
					pc_load <= 1'b1;
					pc_next <= stack_top;
				end
				default: begin
				end
				endcase
			end
		end
	end

	// ========================================
	// Register file writes and interrupt enables
	// No latch-register outputs exist: they are never touched
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			work_we <= 1'b0;
			work_data <= crr_pkg::REG_RESET;
			status_we <= 1'b0;
			status_data <= crr_pkg::REG_RESET;
			bank_we <= 1'b0;
			bank_data <= crr_pkg::REG_RESET;
			irq_en_high_set <= 1'b0;
			irq_en_low_set <= 1'b0;
			soft_reset <= 1'b0;
		end else begin
			work_we <= 1'b0;
			status_we <= 1'b0;
			bank_we <= 1'b0;
			irq_en_high_set <= 1'b0;
			irq_en_low_set <= 1'b0;
			// Registered: high the cycle after each reset word taken; a held word keeps it high
			soft_reset <= exec && op == crr_pkg::CRR_RESET;
			if (exec && op == crr_pkg::CRR_RETIRQ) begin
				irq_en_high_set <= !irq_low_level;
				irq_en_low_set <= irq_low_level;
				if (restore) begin
					work_we <= 1'b1;
					work_data <= work_reg_shadow;
					status_we <= 1'b1;
					status_data <= status_shadow;
					bank_we <= 1'b1;
					bank_data <= bank_select_shadow;
				end
			end else if (exec && op == crr_pkg::CRR_RETLIT) begin
				work_we <= 1'b1;
				work_data <= instr[7:0];
			end
		end
	end

	// ========================================
	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	chk_call_push: assert property (take_call |=> stack_push
		&& stack_push_data == $past(instr_pc) + crr_pkg::PC_STEP)
		else $error("call push wrong");
	chk_call_target: assert property (take_call |=> pc_load
		&& pc_next == $past(instr_pc) + crr_pkg::PC_STEP
		+ $past(disp))
		else $error("call target wrong");
	chk_call_idle: assert property (take_call |=> busy ##1 !busy)
		else $error("call idle slot wrong");
	chk_reset_pulse: assert property (take_reset |=> soft_reset)
		else $error("soft reset missing");
	chk_reset_single: assert property (take_reset |=> !busy
		&& !pc_load && !stack_push && !stack_pop)
		else $error("soft reset not single cycle");
	chk_retirq_pop: assert property (take_retirq |=> stack_pop
		&& pc_load && pc_next == $past(stack_top))
		else $error("irq return pop wrong");
	chk_irq_enable: assert property (take_retirq |=>
		irq_en_low_set == $past(irq_low_level)
		&& irq_en_high_set == !$past(irq_low_level))
		else $error("irq enable wrong");
	chk_enable_only: assert property (!take_retirq |=>
		!irq_en_high_set && !irq_en_low_set)
		else $error("irq enable set outside return");
	chk_restore_off: assert property (take_retirq && !restore |=>
		!status_we && !bank_we && !work_we)
		else $error("restore with bit clear");
	chk_restore_on: assert property (take_retirq && restore |=>
		work_we && work_data == $past(work_reg_shadow)
		&& status_we && status_data == $past(status_shadow)
		&& bank_we && bank_data == $past(bank_select_shadow))
		else $error("restore with bit set wrong");
	chk_retlit_w: assert property (take_retlit |=> work_we
		&& work_data == $past(instr[7:0]) && stack_pop)
		else $error("literal return wrong");
	chk_retlit_pc: assert property (take_retlit |=> pc_load
		&& pc_next == $past(stack_top) && !status_we && !bank_we)
		else $error("literal return pc wrong");
	chk_idle_drop: assert property (busy |=>
		!pc_load && !stack_push && !stack_pop)
		else $error("idle slot executed");
	chk_none_quiet: assert property (take_none |=>
		!busy && !pc_load && !stack_push && !stack_pop
		&& !soft_reset && !work_we)
		else $error("foreign word acted on");

	cov_call: cover property (take_call);
	cov_retirq_s: cover property (take_retirq && restore);
	cov_retirq_n: cover property (take_retirq && !restore);
	cov_retlit: cover property (take_retlit);
	cov_reset: cover property (soft_reset);
endmodule

// *** hdl/crr_pkg.sv ***
/*
 * Package for the call, return and software-reset execution block.
 * Assumes a 21-bit byte program counter and 16-bit instruction words.
 */
package crr_pkg;
	localparam int PC_W = 21;
	localparam int OFS_W = 11;
	// ========================================
	// Opcode patterns
	localparam logic [4:0] OP_CALL_HI = 5'h1b;
	localparam logic [15:0] OP_SWRESET = 16'h00ff;
	localparam logic [14:0] OP_RETIRQ_HI = 15'h0008;
	localparam logic [7:0] OP_RETLIT_HI = 8'h0c;
	localparam int FLD_RESTORE = 0;
	localparam logic [PC_W-1:0] PC_STEP = 21'h2;
	localparam logic [PC_W-1:0] PC_RESET = 21'h0;
	localparam logic [7:0] REG_RESET = 8'h00;
	typedef enum logic [2:0] {
		CRR_NONE, CRR_CALL, CRR_RESET, CRR_RETIRQ, CRR_RETLIT
	} crr_op_e;
endpackage

// *** hdl/crr_decode.sv ***
/*
 * Opcode recogniser for the four control-flow instructions.
 * Assumes a valid fetched word is presented with its strobe.
 */
`timescale 1ns/10ps
module crr_decode (
	input wire logic [15:0] instr,
	output crr_pkg::crr_op_e op
);
	always_comb begin
		if (instr[15:11] == crr_pkg::OP_CALL_HI) begin
			op = crr_pkg::CRR_CALL;
		end else if (instr == crr_pkg::OP_SWRESET) begin
			op = crr_pkg::CRR_RESET;
		end else if (instr[15:1] == crr_pkg::OP_RETIRQ_HI) begin
			op = crr_pkg::CRR_RETIRQ;
		end else if (instr[15:8] == crr_pkg::OP_RETLIT_HI) begin
			op = crr_pkg::CRR_RETLIT;
		end else begin
			op = crr_pkg::CRR_NONE;
		end
	end
endmodule

// *** dv/crr_stack_model.sv ***
/* Return stack stand-in for the execution block.
 Assumes push and pop arrive as one-cycle strobes. */
`timescale 1ns/10ps
module crr_stack_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic push,
	input wire logic [20:0] push_data,
	input wire logic pop,
	output logic [20:0] top
);
	// ==========
	// Stack top
	// A pop shows a fresh entry, never the one just consumed
	always_ff @(posedge clk) begin
		if (sys_rst)
			top <= 21'h0_0200;
		else if (push)
			top <= push_data;
		else if (pop)
			top <= {~top[20:1], 1'b0};
	end
endmodule

// *** dv/tb.sv ***
/* Self-checking bench for crr_exec.
 Assumes crr_stack_model stands in for the return stack. */
`timescale 1ns/10ps
module tb;
	logic clk = 0, sys_rst = 1, vld = 0, lo = 0;
	logic [15:0] instr = 16'h0000;
	logic [20:0] pc = 21'h0, top, e_pc, pd, pn;
	logic [7:0] ws = 8'h00, ss = 8'h00, bs = 8'h00, wd, sd, bd;
	logic psh, pop, ld, wwe, swe, bwe, hs, ls, srst, busy;
	logic [31:0] seed = 32'haec9_a28c, r;
	logic [15:0] w;
	int error_cnt = 0, checked = 0, i;
	always #10 clk = ~clk;
	crr_exec uut (.clk(clk), .sys_rst(sys_rst), .instr(instr),
		.instr_valid(vld), .instr_pc(pc), .stack_top(top),
		.irq_low_level(lo), .work_reg_shadow(ws), .status_shadow(ss),
		.bank_select_shadow(bs), .stack_push(psh), .stack_push_data(pd),
		.stack_pop(pop), .pc_load(ld), .pc_next(pn), .work_we(wwe),
		.work_data(wd), .status_we(swe), .status_data(sd), .bank_we(bwe),
		.bank_data(bd), .irq_en_high_set(hs), .irq_en_low_set(ls),
		.soft_reset(srst), .busy(busy));
	crr_stack_model stk (.clk(clk), .sys_rst(sys_rst), .push(psh),
		.push_data(pd), .pop(pop), .top(top));
	// ==========
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Byte target of a call: address plus 2 plus twice the signed offset
	function automatic logic [20:0] call_dest(input logic [20:0] a,
		input logic [10:0] n);
		return a + 21'h2 + 21'(2 * $signed(n));
	endfunction
	task automatic chk(input string nm, input logic [31:0] got, exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Reset word offered in the idle cycle must be dropped
	task automatic issue(input logic [15:0] wd_i, input logic [20:0] pc_i);
		instr = wd_i;
		pc = pc_i;
		vld = 1;
		e_pc = top;
		@(negedge clk);
		instr = crr_pkg::OP_SWRESET;
	endtask
	task automatic idle();
		@(negedge clk);
		chk("idle", {srst, ld, psh, pop, busy}, 5'h00);
	endtask
	initial begin
		#200_000;
		error_cnt++;
		give_verdict();
	end
	// ==========
	// Scenarios
	initial begin
		repeat (3) @(negedge clk);
		sys_rst = 0;
		for (i = 0; i < 12; i++) begin
			r = rnd();
			w = {5'h1b, i == 0 ? 11'h400 : i == 1 ? 11'h3ff : r[10:0]};
			issue(w, {r[31:12], 1'b0});
			chk("push", {psh, pd}, {1'b1, pc + 21'h2});
			e_pc = call_dest(pc, w[10:0]);
			chk("call", {ld, busy, pn}, {2'b11, e_pc});
			idle();
		end
		for (i = 0; i < 8; i++) begin
			r = rnd();
			{ws, ss, bs} = r[23:0];
			lo = i[1];
			issue({15'h0008, i[0]}, {r[20:1], 1'b0});
			chk("ret pc", {pop, ld, busy, pn}, {3'b111, e_pc});
			chk("irq en", {hs, ls}, {~i[1], i[1]});
			chk("restore", {wwe, swe, bwe}, {3{i[0]}});
			if (i[0])
				chk("shadow", {wd, sd, bd}, r[23:0]);
			idle();
		end
		for (i = 0; i < 6; i++) begin
			r = rnd();
			issue({8'h0c, r[7:0]}, 21'h0_0040);
			chk("lit", {wwe, wd, swe, bwe}, {1'b1, r[7:0], 2'b00});
			chk("lit pc", {pop, ld, busy, pn}, {3'b111, e_pc});
			idle();
		end
		// Words that are none of the four must leave the reset, pc, stack, W and irq-enable strobes low
		for (i = 0; i < 6; i++) begin
			r = rnd();
			w = {(i[0] ? 5'h1a : 5'h1c), r[10:0]};
			instr = i == 0 ? 16'h0012 : i == 1 ? 16'h00fe : w;
			@(negedge clk);
			chk("other", {srst, ld, psh, pop, busy, wwe, hs, ls}, 8'h00);
		end
		issue(crr_pkg::OP_SWRESET, 21'h0);
		chk("reset", {srst, busy, ld}, 3'b100);
		@(negedge clk);
		chk("reset again", srst, 1'b1);
		vld = 0;
		idle();
		give_verdict();
	end
endmodule
